// *** design/pbw_core.sv ***
// Purpose: Device-side executor of the block-oriented PIO write command
// Assumes: Media and backend signals come from logic on clk_sys_i; host regs on a plain port
// Notes: CHS addresses are passed raw; the backend translates them, and the core adds each block's length to step them
//
// What this block does
// - Accept opcode c5 only without packet feature
// - Count zero means 256 sectors
// - Start address from low, mid, high, head
// - Device/head bit 6 selects LBA or CHS
// - Success: busy off, ready on, others clear
// - Error: ready on, fault on fault, error flag
// - Flag write protect and missing media
// - Flag media change, then clear detected state
// - Flag address not found, bad geometry, LBA range
// - Media change request cleared by access commands
// - Abort unsupported or disabled commands
// - Commit error loads failing sector address
// - Status and interrupt only after whole block
// - Data request qualifies only block start
// - Full blocks then remainder partial block
// - Abort when block writes are disabled
// - Post write errors after block, stop there
// - Address regs undefined after failing block
// - Interrupt pending at each block start
`timescale 1ns/1ps
`default_nettype none

module pbw_core #(
    parameter int WORDS_PER_SECTOR = pbw_pkg::WORDS_PER_SECTOR,
    parameter int MAX_SPB = pbw_pkg::MAX_SPB,
    parameter logic [7:0] DEFAULT_SPB = pbw_pkg::DEFAULT_SPB,
    parameter bit PACKET_FS = 1'b0
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Register port
    input wire logic [pbw_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [pbw_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [pbw_pkg::DATA_W-1:0] reg_rdata_o,
    output logic interrupt_line_o,
    // Media state
    input wire pbw_pkg::pbw_media_t media_i,
    input wire logic media_chg_req_i,
    input wire logic [27:0] capacity_i,
    output logic media_chg_ack_o,
    // Backend write path
    output logic [pbw_pkg::DATA_W-1:0] wdata_o,
    output logic wdata_valid_o,
    output pbw_pkg::pbw_blk_req_t blk_req_o,
    output logic blk_req_valid_o,
    input wire logic blk_done_i,
    input wire logic blk_err_i,
    input wire logic [7:0] blk_fail_idx_i
);

    localparam int WORD_W = (WORDS_PER_SECTOR > 1) ? $clog2(WORDS_PER_SECTOR) : 1;
    localparam logic [WORD_W-1:0] WORD_LAST = WORD_W'(WORDS_PER_SECTOR - 1);

    // Refused at elaboration: counters and the 8-bit size register cannot serve these
    if (WORDS_PER_SECTOR < 1 || MAX_SPB < 1 || MAX_SPB > 255 || int'(DEFAULT_SPB) > MAX_SPB) begin : g_bad_param
        $error("pbw_core: unsupported parameter values");
    end

    function automatic logic size_ok(input logic [7:0] v);
        return (v == 8'h00) || ((int'(v) <= MAX_SPB) && ((v & (v - 8'h01)) == 8'h00));
    endfunction

    // ==========================================================
    // State
    pbw_pkg::pbw_state_t st_q;
    logic [7:0] feat_q, cnt_q, lo_q, mid_q, hi_q, dh_q, opc_q;
    logic [7:0] err_q;
    logic busy_q, drive_ready_flag_q, fault_q, drq_q, errf_q;
    logic [7:0] spb_q;
    logic [8:0] remain_q, blk_q, blk_len_q;
    logic [WORD_W-1:0] word_q;
    logic [27:0] lba_q;
    logic mcr_pend_q;
    logic irq_q;

    // ==========================================================
    // Decode
    logic cmd_go, data_wr, tf_wr, stat_rd;
    logic [7:0] opcode;
    logic [8:0] total;
    logic [27:0] start_lba, fail_addr;
    logic over_range, fail_load, commit_bad;
    logic [7:0] chk_err, fin_err;
    logic fin_now, start_now, irq_set;

    assign opcode = reg_wdata_i[7:0];
    // Taskfile writes are ignored while busy or mid-transfer
    assign tf_wr = reg_wr_i && !busy_q && !drq_q;
    assign cmd_go = tf_wr && (reg_addr_i == pbw_pkg::OFS_CMD_STAT) && (st_q == pbw_pkg::PBW_IDLE);
    assign data_wr = reg_wr_i && (reg_addr_i == pbw_pkg::OFS_DATA) && drq_q && (st_q == pbw_pkg::PBW_XFER);
    assign stat_rd = reg_rd_i && (reg_addr_i == pbw_pkg::OFS_CMD_STAT);
    assign total = pbw_pkg::sector_total(cnt_q);
    assign start_lba = {dh_q[3:0], hi_q, mid_q, lo_q};
    // Range is only checked for LBA; CHS limits belong to the backend
    assign over_range = dh_q[pbw_pkg::DH_LBA] &&
                        (({1'b0, start_lba} + 29'(total)) > {1'b0, capacity_i});
    assign commit_bad = blk_err_i || media_i.dev_fault;
    assign fail_load = (st_q == pbw_pkg::PBW_COMMIT) && blk_done_i && commit_bad;
    assign fail_addr = lba_q + 28'(blk_fail_idx_i);
    assign irq_set = fin_now || (st_q == pbw_pkg::PBW_BLK_START);

    always_comb begin
        chk_err = 8'h00;
        if (PACKET_FS || spb_q == 8'h00) begin
            chk_err[pbw_pkg::ER_ABORTED_BIT] = 1'b1;
        end else begin
            chk_err[pbw_pkg::ER_NM] = media_i.no_media;
            chk_err[pbw_pkg::ER_WP] = media_i.write_protect;
            chk_err[pbw_pkg::ER_MC] = media_i.media_changed;
            chk_err[pbw_pkg::ER_MCR] = mcr_pend_q;
            chk_err[pbw_pkg::ER_ADDRESS_NOT_FOUND_BIT] = !media_i.geometry_valid || over_range;
        end
    end

    always_comb begin
        fin_now = 1'b0;
        fin_err = 8'h00;
        start_now = 1'b0;
        if (cmd_go) begin
            case (opcode)
                pbw_pkg::OP_WRITE_BLOCK: begin
                    if (chk_err != 8'h00) begin
                        fin_now = 1'b1;
                        fin_err = chk_err;
                    end else begin
                        start_now = 1'b1;
                    end
                end
                pbw_pkg::OP_SET_BLOCK: begin
                    fin_now = 1'b1;
                    fin_err[pbw_pkg::ER_ABORTED_BIT] = !size_ok(cnt_q);
                end
                pbw_pkg::OP_MEDIA_STATUS: begin
                    fin_now = 1'b1;
                end
                default: begin
                    fin_now = 1'b1;
                    fin_err[pbw_pkg::ER_ABORTED_BIT] = 1'b1;
                end
            endcase
        end else if (st_q == pbw_pkg::PBW_COMMIT && blk_done_i) begin
            // Errors surface only once the whole block has been attempted
            if (commit_bad) begin
                fin_now = 1'b1;
                fin_err[pbw_pkg::ER_ABORTED_BIT] = 1'b1;
            end else if (remain_q == 9'h000) begin
                fin_now = 1'b1;
            end
        end
    end

    // ==========================================================
    // Command sequencer
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q <= pbw_pkg::PBW_IDLE;
            busy_q <= 1'b0;
            drive_ready_flag_q <= 1'b1;
            fault_q <= 1'b0;
            drq_q <= 1'b0;
            errf_q <= 1'b0;
            err_q <= 8'h00;
            remain_q <= 9'h000;
            blk_q <= 9'h000;
            blk_len_q <= 9'h000;
            word_q <= '0;
            lba_q <= 28'h0000000;
        end else if (fin_now) begin
            st_q <= pbw_pkg::PBW_IDLE;
            busy_q <= 1'b0;
            drq_q <= 1'b0;
            drive_ready_flag_q <= 1'b1;
            err_q <= fin_err;
            errf_q <= (fin_err != 8'h00);
            fault_q <= (fin_err != 8'h00) && media_i.dev_fault;
        end else if (start_now) begin
            st_q <= pbw_pkg::PBW_BLK_START;
            busy_q <= 1'b1;
            err_q <= 8'h00;
            errf_q <= 1'b0;
            fault_q <= 1'b0;
            remain_q <= total;
            lba_q <= start_lba;
        end else begin
            unique case (st_q)
                pbw_pkg::PBW_IDLE: begin
                end
                pbw_pkg::PBW_BLK_START: begin
                    // Last block carries the remainder
                    if (remain_q < {1'b0, spb_q}) begin
                        blk_q <= remain_q;
                        blk_len_q <= remain_q;
                    end else begin
                        blk_q <= {1'b0, spb_q};
                        blk_len_q <= {1'b0, spb_q};
                    end
                    word_q <= '0;
                    drq_q <= 1'b1;
                    busy_q <= 1'b0;
                    st_q <= pbw_pkg::PBW_XFER;
                end
                pbw_pkg::PBW_XFER: begin
                    if (data_wr) begin
                        if (word_q == WORD_LAST) begin
                            word_q <= '0;
                            remain_q <= remain_q - 9'h001;
                            blk_q <= blk_q - 9'h001;
                            // Flags held until the block's final sector is in
                            if (blk_q == 9'h001) begin
                                drq_q <= 1'b0;
                                busy_q <= 1'b1;
                                st_q <= pbw_pkg::PBW_COMMIT;
                            end
                        end else begin
                            word_q <= word_q + WORD_W'(1);
                        end
                    end
                end
                pbw_pkg::PBW_COMMIT: begin
                    if (blk_done_i) begin
                        lba_q <= lba_q + 28'(blk_len_q);
                        st_q <= pbw_pkg::PBW_BLK_START;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Block size setting
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            spb_q <= DEFAULT_SPB;
        end else if (cmd_go && opcode == pbw_pkg::OP_SET_BLOCK && size_ok(cnt_q)) begin
            spb_q <= cnt_q;
        end
    end

    // ==========================================================
    // Taskfile registers
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            feat_q <= pbw_pkg::RST_TASKFILE;
            cnt_q <= pbw_pkg::RST_COUNT;
            lo_q <= pbw_pkg::RST_COUNT;
            mid_q <= pbw_pkg::RST_TASKFILE;
            hi_q <= pbw_pkg::RST_TASKFILE;
            dh_q <= pbw_pkg::RST_TASKFILE;
            opc_q <= pbw_pkg::RST_TASKFILE;
        end else if (fail_load) begin
            // Later address state is undefined; retry singly for exact detail
            lo_q <= fail_addr[7:0];
            mid_q <= fail_addr[15:8];
            hi_q <= fail_addr[23:16];
            dh_q[3:0] <= fail_addr[27:24];
        end else if (tf_wr) begin
            unique case (reg_addr_i)
                pbw_pkg::OFS_FEAT_ERR: feat_q <= reg_wdata_i[7:0];
                pbw_pkg::OFS_COUNT: cnt_q <= reg_wdata_i[7:0];
                pbw_pkg::OFS_ADDR_LOW: lo_q <= reg_wdata_i[7:0];
                pbw_pkg::OFS_ADDR_MID: mid_q <= reg_wdata_i[7:0];
                pbw_pkg::OFS_ADDR_HIGH: hi_q <= reg_wdata_i[7:0];
                pbw_pkg::OFS_DEV_HEAD: dh_q <= reg_wdata_i[7:0];
                pbw_pkg::OFS_CMD_STAT: opc_q <= reg_wdata_i[7:0];
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // Media change request and acknowledge
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mcr_pend_q <= 1'b0;
            media_chg_ack_o <= 1'b0;
        end else begin
            // A new request in the clearing cycle survives
            mcr_pend_q <= media_chg_req_i || (mcr_pend_q && !(cmd_go &&
                          (opcode == pbw_pkg::OP_WRITE_BLOCK || opcode == pbw_pkg::OP_MEDIA_STATUS)));
            media_chg_ack_o <= cmd_go && opcode == pbw_pkg::OP_WRITE_BLOCK &&
                               chk_err[pbw_pkg::ER_MC];
        end
    end

    // ==========================================================
    // Interrupt line
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_set || (irq_q && !stat_rd && !cmd_go);
        end
    end
    assign interrupt_line_o = irq_q;

    // ==========================================================
    // Backend outputs
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wdata_o <= '0;
            wdata_valid_o <= 1'b0;
            blk_req_o <= '0;
            blk_req_valid_o <= 1'b0;
        end else begin
            wdata_o <= reg_wdata_i;
            wdata_valid_o <= data_wr;
            blk_req_valid_o <= data_wr && word_q == WORD_LAST && blk_q == 9'h001;
            blk_req_o <= '{lba_mode: dh_q[pbw_pkg::DH_LBA], lba: lba_q, count: blk_len_q};
        end
    end

    // ==========================================================
    // Read port
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= '0;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                pbw_pkg::OFS_FEAT_ERR: reg_rdata_o <= {8'h00, err_q};
                pbw_pkg::OFS_COUNT: reg_rdata_o <= {8'h00, cnt_q};
                pbw_pkg::OFS_ADDR_LOW: reg_rdata_o <= {8'h00, lo_q};
                pbw_pkg::OFS_ADDR_MID: reg_rdata_o <= {8'h00, mid_q};
                pbw_pkg::OFS_ADDR_HIGH: reg_rdata_o <= {8'h00, hi_q};
                pbw_pkg::OFS_DEV_HEAD: reg_rdata_o <= {8'h00, dh_q};
                pbw_pkg::OFS_CMD_STAT: reg_rdata_o <= {8'h00, busy_q, drive_ready_flag_q, fault_q, 1'b0, drq_q, 2'b00, errf_q};
                pbw_pkg::OFS_BLOCK_SIZE: reg_rdata_o <= {8'h00, spb_q};
                default: reg_rdata_o <= '0;
            endcase
        end else begin
            reg_rdata_o <= '0;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    cnt_zero_a: assert property (start_now && cnt_q == 8'h00 |=> remain_q == 9'h100)
        else $error("zero count did not give 256 sectors");
    start_addr_a: assert property (start_now |=> lba_q == $past(start_lba))
        else $error("start address not formed from taskfile");
    ok_status_a: assert property (fin_now && fin_err == 8'h00 |=> !busy_q && drive_ready_flag_q && !fault_q && !drq_q && !errf_q)
        else $error("bad status after good completion");
    err_status_a: assert property (fin_now && fin_err != 8'h00 |=> errf_q && drive_ready_flag_q && !busy_q && !drq_q)
        else $error("bad status after error completion");
    mid_irq_a: assert property (st_q == pbw_pkg::PBW_XFER && !irq_q |=> !irq_q)
        else $error("interrupt raised inside a block");
    drq_hold_a: assert property (st_q == pbw_pkg::PBW_XFER |-> drq_q && !busy_q)
        else $error("data request dropped inside a block");
    blk_irq_a: assert property (st_q == pbw_pkg::PBW_BLK_START |=> irq_q && drq_q)
        else $error("block start without interrupt pending");
    blk_len_a: assert property (st_q == pbw_pkg::PBW_BLK_START |=> blk_len_q != 9'h000 &&
        (blk_len_q == {1'b0, spb_q} || (blk_len_q == remain_q && remain_q < {1'b0, spb_q})))
        else $error("block length is neither full nor remainder");
    dis_abort_a: assert property (cmd_go && opcode == pbw_pkg::OP_WRITE_BLOCK && spb_q == 8'h00
        |=> err_q[pbw_pkg::ER_ABORTED_BIT] && errf_q && st_q == pbw_pkg::PBW_IDLE)
        else $error("disabled block write not aborted");
    fail_addr_a: assert property (fail_load |=> {dh_q[3:0], hi_q, mid_q, lo_q} == $past(fail_addr) &&
        st_q == pbw_pkg::PBW_IDLE && !blk_req_valid_o)
        else $error("failing sector address not loaded");
    sector_cnt_a: assert property (data_wr && word_q == WORD_LAST |=> remain_q == $past(remain_q) - 9'h001)
        else $error("remaining count not decremented per sector");
    media_chg_a: assert property (media_chg_ack_o |-> err_q[pbw_pkg::ER_MC] && errf_q)
        else $error("media change acknowledged without reporting");

endmodule

`default_nettype wire

// *** design/pbw_pkg.sv ***
// Purpose: Shared constants and types for the block-oriented PIO write command unit
// Assumes: Taskfile registers sit at small word indices on a plain register port
// Notes: Opcodes other than the block write are only those the unit must recognise
package pbw_pkg;

    // ==========================================================
    // Register port
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [3:0] OFS_DATA = 4'h0;
    localparam logic [3:0] OFS_FEAT_ERR = 4'h1;
    localparam logic [3:0] OFS_COUNT = 4'h2;
    localparam logic [3:0] OFS_ADDR_LOW = 4'h3;
    localparam logic [3:0] OFS_ADDR_MID = 4'h4;
    localparam logic [3:0] OFS_ADDR_HIGH = 4'h5;
    localparam logic [3:0] OFS_DEV_HEAD = 4'h6;
    localparam logic [3:0] OFS_CMD_STAT = 4'h7;
    localparam logic [3:0] OFS_BLOCK_SIZE = 4'h8;

    // ==========================================================
    // Opcodes
    localparam logic [7:0] OP_WRITE_BLOCK = 8'hc5;
    localparam logic [7:0] OP_SET_BLOCK = 8'hc6;
    localparam logic [7:0] OP_MEDIA_STATUS = 8'hda;

    // ==========================================================
    // Field positions
    localparam int ST_BUSY = 7;
    localparam int ST_READY = 6;
    localparam int ST_FAULT = 5;
    localparam int ST_DREQ = 3;
    localparam int ST_ERR = 0;
    localparam int ER_WP = 6;
    localparam int ER_MC = 5;
    localparam int ER_ADDRESS_NOT_FOUND_BIT = 4;
    localparam int ER_MCR = 3;
    localparam int ER_ABORTED_BIT = 2;
    localparam int ER_NM = 1;
    localparam int DH_LBA = 6;

    // ==========================================================
    // Counts and reset values
    localparam logic [8:0] MAX_SECTORS = 9'h100;
    localparam int WORDS_PER_SECTOR = 256;
    localparam logic [7:0] DEFAULT_SPB = 8'h10;
    localparam int MAX_SPB = 128;
    localparam logic [7:0] RST_TASKFILE = 8'h00;
    localparam logic [7:0] RST_COUNT = 8'h01;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        PBW_IDLE = 2'b00,
        PBW_BLK_START = 2'b01,
        PBW_XFER = 2'b10,
        PBW_COMMIT = 2'b11
    } pbw_state_t;

    typedef struct packed {
        logic lba_mode;
        logic [27:0] lba;
        logic [8:0] count;
    } pbw_blk_req_t;

    typedef struct packed {
        logic write_protect;
        logic no_media;
        logic media_changed;
        logic geometry_valid;
        logic dev_fault;
    } pbw_media_t;

    // Count register value to sectors; zero stands for the maximum
    function automatic logic [8:0] sector_total(input logic [7:0] c);
        return (c == 8'h00) ? MAX_SECTORS : {1'b0, c};
    endfunction

endpackage

// *** bench/pbw_backend_model.sv ***
// Purpose: Backend model that commits the blocks of the write command unit
// Assumes: One commit in flight at a time; the answer comes after a settable delay
// Notes: Outside a done pulse the error lines toggle, so a stale value is never trusted
`timescale 1ns/1ps
`default_nettype none

module pbw_backend_model (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // From the unit
    input wire pbw_pkg::pbw_blk_req_t blk_req_i,
    input wire logic blk_req_valid_i,
    input wire logic wdata_valid_i,
    // Test controls
    input wire logic err_en_i,
    input wire logic [7:0] fail_idx_i,
    input wire logic [3:0] delay_i,
    // Answers and records
    output logic blk_done_o,
    output logic blk_err_o,
    output logic [7:0] blk_fail_idx_o,
    output pbw_pkg::pbw_blk_req_t last_req_o,
    output logic [15:0] words_o
);
    logic pend_q;
    logic [3:0] wait_q;

    // ==========================================================
    // Commit sequencing
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            {pend_q, wait_q, blk_done_o, blk_err_o, blk_fail_idx_o, last_req_o, words_o} <= '0;
        end else begin
            blk_done_o <= 1'b0;
            blk_err_o <= ~blk_err_o;
            blk_fail_idx_o <= ~blk_fail_idx_o;
            if (wdata_valid_i) begin
                words_o <= words_o + 16'h0001;
            end
            if (blk_req_valid_i) begin
                last_req_o <= blk_req_i;
                wait_q <= delay_i;
                pend_q <= 1'b1;
            end else if (pend_q && wait_q != 4'h0) begin
                wait_q <= wait_q - 4'h1;
            end else if (pend_q) begin
                // Failure names one sector inside the block just written
                blk_done_o <= 1'b1;
                blk_err_o <= err_en_i;
                blk_fail_idx_o <= fail_idx_i;
                pend_q <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
// Purpose: Self-checking bench for the block-oriented PIO write command unit
// Assumes: Sectors shortened to 4 words to keep the run brief
// Notes: Every scenario task drives the unit and judges the outcome itself
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end

module testbench;
    localparam int WPS = 4;
    localparam int LIMIT = 20000;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdat = 16'h0000;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [15:0] rdat;
    logic interrupt_line;
    pbw_pkg::pbw_media_t media = 5'b00010;
    logic chg_req = 1'b0;
    logic [27:0] cap = 28'hfffffff;
    logic chg_ack, wvalid, req_valid, done, berr, ack_seen = 1'b0, err_en = 1'b0;
    logic [15:0] wout, words, last_w;
    pbw_pkg::pbw_blk_req_t req, last_req;
    logic [7:0] fidx, fail_idx = 8'h01;
    logic [3:0] delay = 4'h0;
    int num_checks = 0;
    int mismatches = 0;
    int cycles = 0;

    always #4 clk = ~clk;

    pbw_core #(.WORDS_PER_SECTOR(WPS)) u_dut (.clk_sys_i(clk), .resetn_i(resetn), .reg_addr_i(addr),
        .reg_wdata_i(wdat), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdat), .interrupt_line_o(interrupt_line),
        .media_i(media), .media_chg_req_i(chg_req), .capacity_i(cap), .media_chg_ack_o(chg_ack),
        .wdata_o(wout), .wdata_valid_o(wvalid), .blk_req_o(req), .blk_req_valid_o(req_valid),
        .blk_done_i(done), .blk_err_i(berr), .blk_fail_idx_i(fidx));

    pbw_backend_model u_back (.clk_sys_i(clk), .resetn_i(resetn), .blk_req_i(req),
        .blk_req_valid_i(req_valid), .wdata_valid_i(wvalid), .err_en_i(err_en), .fail_idx_i(fail_idx),
        .delay_i(delay), .blk_done_o(done), .blk_err_o(berr), .blk_fail_idx_o(fidx),
        .last_req_o(last_req), .words_o(words));

    // ==========================================================
    // Watchdog and media change acknowledge capture
    always @(posedge clk) begin
        cycles++;
        if (chg_ack === 1'b1) begin
            ack_seen <= 1'b1;
        end
        if (wvalid === 1'b1) begin
            last_w <= wout;
        end
        if (cycles == LIMIT) begin
            mismatches++;
            summarize;
        end
    end

    // ==========================================================
    // Register port tasks; each ends on a rising edge
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        addr <= a;
        wdat <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 d = rdat[7:0];
        @(posedge clk);
    endtask

    task automatic wait_irq;
        int i;
        for (i = 0; i < 100 && interrupt_line !== 1'b1; i++) begin
            @(posedge clk);
        end
        `CHK("interrupt_line", 1'b1, interrupt_line)
    endtask

    task automatic send(input int n);
        int i;
        for (i = 0; i < n * WPS; i++) begin
            wr(4'h0, i[15:0]);
        end
    endtask

    task automatic setup(input logic [7:0] c, input logic [27:0] a, input logic m);
        wr(4'h2, {8'h00, c});
        wr(4'h3, {8'h00, a[7:0]});
        wr(4'h4, {8'h00, a[15:8]});
        wr(4'h5, {8'h00, a[23:16]});
        wr(4'h6, {9'h000, m, 2'b00, a[27:24]});
    endtask

    task automatic setspb(input logic [7:0] n);
        logic [7:0] s;
        wr(4'h2, {8'h00, n});
        wr(4'h7, {8'h00, pbw_pkg::OP_SET_BLOCK});
        wait_irq;
        rd(4'h7, s);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset;
        logic [7:0] s;
        rd(4'h7, s);
        `CHK("status", 8'h40, s)
        rd(4'h8, s);
        `CHK("block size", pbw_pkg::DEFAULT_SPB, s)
        rd(4'h9, s);
        `CHK("unmapped", 8'h00, s)
    endtask

    task automatic t_multi;
        logic [7:0] s;
        logic [15:0] w0;
        delay <= 4'h3;
        setspb(8'h02);
        setup(8'h03, 28'h5332211, 1'b1);
        w0 = words;
        wr(4'h7, {8'h00, pbw_pkg::OP_WRITE_BLOCK});
        wait_irq;
        rd(4'h7, s);
        `CHK("first drq", 8'h08, s & 8'h88)
        send(1);
        `CHK("mid irq", 1'b0, interrupt_line)
        rd(4'h7, s);
        `CHK("mid status", 8'h08, s & 8'ha9)
        `CHK("last word", 16'h0003, last_w)
        send(1);
        wait_irq;
        `CHK("block one", {1'b1, 28'h5332211, 9'd2}, last_req)
        rd(4'h7, s);
        `CHK("second drq", 8'h08, s & 8'h88)
        send(1);
        wait_irq;
        `CHK("block two", {1'b1, 28'h5332213, 9'd1}, last_req)
        rd(4'h7, s);
        `CHK("done status", 8'h40, s)
        `CHK("words", 16'(3 * WPS), words - w0)
    endtask

    task automatic t_count0;
        logic [7:0] s;
        logic [15:0] w0;
        int b;
        delay <= 4'h0;
        setspb(8'h80);
        setup(8'h00, 28'h0000100, 1'b1);
        w0 = words;
        wr(4'h7, {8'h00, pbw_pkg::OP_WRITE_BLOCK});
        for (b = 0; b < 2; b++) begin
            wait_irq;
            rd(4'h7, s);
            send(128);
        end
        wait_irq;
        `CHK("last block", {1'b1, 28'h0000180, 9'd128}, last_req)
        rd(4'h7, s);
        `CHK("done status", 8'h40, s)
        `CHK("words", 16'(256 * WPS), words - w0)
    endtask

    task automatic t_abort;
        logic [7:0] s;
        setspb(8'h00);
        wr(4'h7, {8'h00, pbw_pkg::OP_WRITE_BLOCK});
        wait_irq;
        rd(4'h1, s);
        `CHK("disabled", 8'h04, s)
        rd(4'h7, s);
        `CHK("err status", 8'h41, s)
        wr(4'h7, 16'h00ff);
        wait_irq;
        rd(4'h1, s);
        `CHK("unknown op", 8'h04, s)
        rd(4'h7, s);
    endtask

    task automatic t_media;
        logic [7:0] s;
        logic [4:0] mv [5] = '{5'b10010, 5'b01010, 5'b00110, 5'b00000, 5'b00010};
        logic [7:0] ev [5] = '{8'h48, 8'h02, 8'h20, 8'h10, 8'h10};
        int i;
        setspb(8'h02);
        // Request pending: reported by the first write, cleared by it for the next
        chg_req <= 1'b1;
        @(posedge clk);
        chg_req <= 1'b0;
        for (i = 0; i < 5; i++) begin
            media <= pbw_pkg::pbw_media_t'(mv[i]);
            cap <= (i == 4) ? 28'h0000000 : 28'hfffffff;
            setup(8'h01, 28'h0000000, 1'b1);
            wr(4'h7, {8'h00, pbw_pkg::OP_WRITE_BLOCK});
            wait_irq;
            rd(4'h1, s);
            `CHK("media error", ev[i], s)
            rd(4'h7, s);
            `CHK("err status", 8'h41, s)
        end
        wr(4'h7, {8'h00, pbw_pkg::OP_MEDIA_STATUS});
        wait_irq;
        rd(4'h1, s);
        `CHK("media status", 8'h00, s)
        `CHK("change ack", 1'b1, ack_seen)
        media <= 5'b00010;
        cap <= 28'hfffffff;
    endtask

    task automatic t_cerr;
        logic [7:0] s;
        err_en <= 1'b1;
        delay <= 4'h9;
        setup(8'h04, 28'h0000100, 1'b0);
        wr(4'h7, {8'h00, pbw_pkg::OP_WRITE_BLOCK});
        wait_irq;
        rd(4'h7, s);
        send(2);
        wait_irq;
        `CHK("chs mode", 1'b0, last_req.lba_mode)
        rd(4'h7, s);
        `CHK("no next block", 8'h41, s)
        rd(4'h1, s);
        `CHK("commit error", 8'h04, s)
        rd(4'h3, s);
        `CHK("fail low", 8'h01, s)
        rd(4'h4, s);
        `CHK("fail mid", 8'h01, s)
        err_en <= 1'b0;
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_reset;
        t_multi;
        t_count0;
        t_abort;
        t_media;
        t_cerr;
        summarize;
    end
endmodule
`default_nettype wire
